/* File: rtl/fspr_map.svh */
`ifndef FSPR_MAP_SVH
`define FSPR_MAP_SVH

// ****************************************
// Instruction codes
// ****************************************
`define FSPR_OP_WR_ENABLE 8'h06
`define FSPR_OP_WR_DISABLE 8'h04
`define FSPR_OP_VOL_ENABLE 8'h50
`define FSPR_OP_STAT_WRITE 8'h01
`define FSPR_OP_STAT_READ 8'h05
`define FSPR_OP_PAGE_PROG 8'h02
`define FSPR_OP_QUAD_PROG 8'h32
`define FSPR_OP_SECT_WIPE 8'h20
`define FSPR_OP_BLOCK_WIPE 8'hd8
`define FSPR_OP_CHIP_WIPE 8'hc7
`define FSPR_OP_CHIP_WIPE2 8'h60
`define FSPR_OP_OTP_ENTER 8'h3a

// ****************************************
// Status bit positions, both views
// ****************************************
`define FSPR_BIT_WIP 0
`define FSPR_BIT_WEL 1
`define FSPR_BIT_LOCK 7
`define FSPR_BIT_BOOT 6
`define FSPR_BIT_PDIS 6
`define FSPR_BIT_HRSEL 5
`define FSPR_BIT_GRAN 4
`define FSPR_BIT_TB 3

// ****************************************
// Reset values and frame lengths
// ****************************************
`define FSPR_RST_BP 4'h0
`define FSPR_RST_BIT 1'b0
`define FSPR_BITS_OPC 6'h08
`define FSPR_BITS_DATA 6'h10
`define FSPR_BITS_ADDR 6'h20
`define FSPR_LAST_BLOCK 7'h7f
`define FSPR_LAST_SECTOR 11'h7ff

// ****************************************
// Timing
// ****************************************
`define FSPR_CLK_MHZ 50
`define FSPR_SW_TIME_US 10
`define FSPR_SW_CYCLES (`FSPR_SW_TIME_US * `FSPR_CLK_MHZ)

`endif

/* File: rtl/fspr_pkg.sv */
package fspr_pkg;

	// Busy phases behind write_in_progress
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SWRITE = 2'b01,
		ST_ARRAY = 2'b10
	} fspr_st_t;

	// Array operation handed to the engine
	typedef enum logic [1:0] {
		OP_PROG = 2'b00,
		OP_SECT = 2'b01,
		OP_BLOCK = 2'b10,
		OP_CHIP = 2'b11
	} fspr_op_t;

	// Whole module state
	typedef struct packed {
		logic sclk_m, sclk_s, sclk_d;
		logic cs_m, cs_s, cs_d;
		logic di_m, di_s;
		logic wp_m, wp_s;
		logic hd_m, hd_s;
		logic [5:0] bit_cnt;
		logic [31:0] shift;
		logic [7:0] opcode;
		logic [7:0] wdata;
		logic [23:0] addr;
		logic [7:0] rd_byte;
		logic so, so_oe;
		fspr_st_t st;
		logic [9:0] sw_cnt;
		logic [7:0] pend;
		logic pend_otp;
		logic write_in_progress, write_enable_latch, vol_arm, otp_mode;
		logic status_lock_bit, boot_lock_enable;
		logic [3:0] bp;
		logic otp_lock, pdis, hrsel, gran4k, tb;
		logic hold, pin_reset;
		logic start;
		fspr_op_t op;
		logic [23:0] a_addr;
		logic a_otp;
	} fspr_state_t;

endpackage

/* File: rtl/fspr_top.sv */
`include "fspr_map.svh"

module fspr_top
	import fspr_pkg::*;
#(
	// Protected 64KB block count per protect code, code 0 in low byte
	parameter logic [127:0] P_BP_LUT = 128'h80_80_80_80_80_80_80_80_40_20_10_08_04_02_01_00
) (
	input wire logic i_sys_clk, // System clock
	input wire logic i_rst_n, // Async reset
	input wire logic i_sclk, // Serial clock pin
	input wire logic i_cs_n, // Chip select pin
	input wire logic i_di, // Serial data in pin
	input wire logic i_wp_n, // Write protect pin
	input wire logic i_hold_n, // Shared hold/reset pin
	input wire logic i_quad_mode, // Quad commands active
	input wire logic i_array_done, // Engine finished pulse
	output logic o_so, // Serial data out
	output logic o_so_oe, // Data out enable
	output logic o_wip, // Write in progress
	output logic o_wel, // Write enable latch
	output logic [3:0] o_bp, // Block protect code
	output logic o_tb, // Top/bottom select
	output logic o_ebl, // Boot lock enable
	output logic o_gran4k, // Boot lock granularity
	output logic o_otp_mode, // OTP view active
	output logic o_otp_lock, // OTP area locked
	output logic o_hold, // Hold in force
	output logic o_pin_reset, // Reset request from pin
	output logic o_array_start, // Start engine pulse
	output logic [1:0] o_array_op, // Engine operation
	output logic [23:0] o_array_addr, // Engine address
	output logic o_array_otp // Target is OTP sector
);

	// ****************************************
	// State register
	// ****************************************
	fspr_state_t s_reg, s_next;

	logic rise, fall, frame_end;
	logic pins_en, hpm, idle, blocked;
	logic bp_hit, boot_hit;
	logic [7:0] view, nblk;
	logic [7:0] blk_sum;
	logic [6:0] blk;
	logic [10:0] sec;
	logic is_prog, is_sect, is_block, is_chip;
	fspr_op_t new_op;

	// ****************************************
	// Protection decode
	// ****************************************
	// Protect pins dead under quad mode or pin disable
	assign pins_en = ~s_reg.pdis & ~i_quad_mode;
	assign hpm = s_reg.status_lock_bit & pins_en & ~s_reg.wp_s;
	assign idle = (s_reg.st == ST_IDLE);
	assign blk = s_reg.addr[22:16];
	assign sec = s_reg.addr[22:12];
	assign nblk = P_BP_LUT[{s_reg.bp, 3'h0} +: 8];
	assign blk_sum = {1'b0, blk} + nblk;

	// Range from the top end or the bottom end
	always_comb begin
		if (s_reg.tb) begin
			bp_hit = ({1'b0, blk} < nblk);
		end else begin
			bp_hit = blk_sum[7];
		end
	end

	// Boot lock covers one end sector or block
	always_comb begin
		if (!s_reg.boot_lock_enable) begin
			boot_hit = 1'b0;
		end else if (s_reg.gran4k && s_reg.opcode != `FSPR_OP_BLOCK_WIPE) begin
			boot_hit = s_reg.tb ? (sec == 11'h000) : (sec == `FSPR_LAST_SECTOR);
		end else if (s_reg.gran4k) begin
			// Block erase still hits the boot sector inside
			boot_hit = s_reg.tb ? (blk == 7'h00) : (blk == `FSPR_LAST_BLOCK);
		end else begin
			boot_hit = s_reg.tb ? (blk == 7'h00) : (blk == `FSPR_LAST_BLOCK);
		end
	end

	// OTP mode targets the OTP sector only
	assign blocked = s_reg.otp_mode ? s_reg.otp_lock : (bp_hit | boot_hit);

	// Read view; bit 2 of OTP view forced low
	always_comb begin
		if (s_reg.otp_mode) begin
			view = {s_reg.otp_lock, s_reg.pdis, s_reg.hrsel, s_reg.gran4k,
				s_reg.tb, 1'b0, s_reg.write_enable_latch, s_reg.write_in_progress};
		end else begin
			view = {s_reg.status_lock_bit, s_reg.boot_lock_enable, s_reg.bp, s_reg.write_enable_latch, s_reg.write_in_progress};
		end
	end

	// ****************************************
	// Command classes
	// ****************************************
	assign is_prog = (s_reg.opcode == `FSPR_OP_PAGE_PROG)
		|| (s_reg.opcode == `FSPR_OP_QUAD_PROG);
	assign is_sect = (s_reg.opcode == `FSPR_OP_SECT_WIPE);
	assign is_block = (s_reg.opcode == `FSPR_OP_BLOCK_WIPE);
	assign is_chip = (s_reg.opcode == `FSPR_OP_CHIP_WIPE)
		|| (s_reg.opcode == `FSPR_OP_CHIP_WIPE2);

	always_comb begin
		if (is_sect) begin
			new_op = OP_SECT;
		end else if (is_block) begin
			new_op = OP_BLOCK;
		end else begin
			new_op = OP_PROG;
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_next = s_reg;
		s_next.start = 1'b0;
		// Two flops per pin before use
		s_next.sclk_m = i_sclk;
		s_next.sclk_s = s_reg.sclk_m;
		s_next.sclk_d = s_reg.sclk_s;
		s_next.cs_m = i_cs_n;
		s_next.cs_s = s_reg.cs_m;
		s_next.cs_d = s_reg.cs_s;
		s_next.di_m = i_di;
		s_next.di_s = s_reg.di_m;
		s_next.wp_m = i_wp_n;
		s_next.wp_s = s_reg.wp_m;
		s_next.hd_m = i_hold_n;
		s_next.hd_s = s_reg.hd_m;

		// Shared pin: hold or reset, or plain data
		s_next.hold = pins_en & ~s_reg.hrsel & ~s_reg.hd_s;
		s_next.pin_reset = pins_en & s_reg.hrsel & ~s_reg.hd_s;

		// Edges are ignored while hold is in force
		rise = s_reg.sclk_s & ~s_reg.sclk_d & ~s_reg.cs_s & ~s_reg.hold;
		fall = ~s_reg.sclk_s & s_reg.sclk_d & ~s_reg.cs_s & ~s_reg.hold;
		frame_end = s_reg.cs_s & ~s_reg.cs_d;

		// Shift in on rising edge
		if (rise) begin
			s_next.shift = {s_reg.shift[30:0], s_reg.di_s};
			if (s_reg.bit_cnt != 6'h3f) begin
				s_next.bit_cnt = s_reg.bit_cnt + 6'h01;
			end
			if (s_reg.bit_cnt == `FSPR_BITS_OPC - 6'h01) begin
				s_next.opcode = {s_reg.shift[6:0], s_reg.di_s};
			end
			if (s_reg.bit_cnt == `FSPR_BITS_DATA - 6'h01) begin
				s_next.wdata = {s_reg.shift[6:0], s_reg.di_s};
			end
			if (s_reg.bit_cnt == `FSPR_BITS_ADDR - 6'h01) begin
				s_next.addr = {s_reg.shift[22:0], s_reg.di_s};
			end
		end

		// Shift out on falling edge; byte repeats until the bit count saturates at 63
		if (fall && s_reg.opcode == `FSPR_OP_STAT_READ && s_reg.bit_cnt >= `FSPR_BITS_OPC) begin
			s_next.so_oe = 1'b1;
			if (s_reg.bit_cnt[2:0] == 3'h0) begin
				s_next.so = view[7];
				s_next.rd_byte = {view[6:0], 1'b0};
			end else begin
				s_next.so = s_reg.rd_byte[7];
				s_next.rd_byte = {s_reg.rd_byte[6:0], 1'b0};
			end
		end
		if (s_reg.cs_s || s_reg.hold) begin
			s_next.so_oe = 1'b0;
		end

		// Busy phases
		case (s_reg.st)
			ST_SWRITE: begin
				if (s_reg.sw_cnt == 10'h000) begin
					if (s_reg.pend_otp) begin
						s_next.otp_lock = s_reg.otp_lock | s_reg.pend[`FSPR_BIT_LOCK];
						s_next.pdis = s_reg.pend[`FSPR_BIT_PDIS];
						s_next.hrsel = s_reg.pend[`FSPR_BIT_HRSEL];
						s_next.gran4k = s_reg.pend[`FSPR_BIT_GRAN];
						s_next.tb = s_reg.pend[`FSPR_BIT_TB];
					end else begin
						s_next.status_lock_bit = s_reg.pend[7];
						s_next.boot_lock_enable = s_reg.pend[6];
						s_next.bp = s_reg.pend[5:2];
					end
					s_next.write_enable_latch = 1'b0;
					s_next.st = ST_IDLE;
				end else begin
					s_next.sw_cnt = s_reg.sw_cnt - 10'h001;
				end
			end
			ST_ARRAY: begin
				if (i_array_done) begin
					s_next.write_enable_latch = 1'b0;
					s_next.st = ST_IDLE;
				end
			end
			default: begin
				s_next.st = ST_IDLE;
			end
		endcase

		// Execute at chip select release
		if (frame_end) begin
			s_next.bit_cnt = 6'h00;
			s_next.vol_arm = 1'b0;
			if (s_reg.bit_cnt == `FSPR_BITS_OPC) begin
				if (s_reg.opcode == `FSPR_OP_WR_ENABLE && idle) begin
					s_next.write_enable_latch = 1'b1;
				end else if (s_reg.opcode == `FSPR_OP_WR_DISABLE && idle) begin
					s_next.write_enable_latch = 1'b0;
					s_next.otp_mode = 1'b0;
				end else if (s_reg.opcode == `FSPR_OP_VOL_ENABLE) begin
					s_next.vol_arm = 1'b1;
				end else if (s_reg.opcode == `FSPR_OP_OTP_ENTER && idle) begin
					s_next.otp_mode = 1'b1;
				end else if (is_chip && idle && s_reg.write_enable_latch && !s_reg.otp_mode
					&& s_reg.bp == 4'h0 && !s_reg.boot_lock_enable) begin
					s_next.start = 1'b1;
					s_next.op = OP_CHIP;
					s_next.a_addr = 24'h000000;
					s_next.a_otp = 1'b0;
					s_next.st = ST_ARRAY;
				end
			end else if (s_reg.bit_cnt == `FSPR_BITS_DATA
				&& s_reg.opcode == `FSPR_OP_STAT_WRITE && idle && !hpm) begin
				if (s_reg.vol_arm) begin
					// Volatile copy only, latch untouched
					if (s_reg.otp_mode) begin
						s_next.pdis = s_reg.wdata[`FSPR_BIT_PDIS];
						s_next.hrsel = s_reg.wdata[`FSPR_BIT_HRSEL];
						s_next.gran4k = s_reg.wdata[`FSPR_BIT_GRAN];
						s_next.tb = s_reg.wdata[`FSPR_BIT_TB];
					end else begin
						s_next.status_lock_bit = s_reg.wdata[7];
						s_next.boot_lock_enable = s_reg.wdata[6];
						s_next.bp = s_reg.wdata[5:2];
					end
				end else if (s_reg.write_enable_latch) begin
					s_next.pend = s_reg.wdata;
					s_next.pend_otp = s_reg.otp_mode;
					s_next.sw_cnt = 10'(`FSPR_SW_CYCLES - 1);
					s_next.st = ST_SWRITE;
				end
			end else if (s_reg.bit_cnt >= `FSPR_BITS_ADDR && (is_prog || is_sect || is_block)
				&& idle && s_reg.write_enable_latch && !blocked) begin
				s_next.start = 1'b1;
				s_next.op = new_op;
				s_next.a_addr = s_reg.addr;
				s_next.a_otp = s_reg.otp_mode;
				s_next.st = ST_ARRAY;
			end
		end

		// Busy flag follows the phase, both status views share it
		s_next.write_in_progress = (s_next.st != ST_IDLE);
	end

	// ****************************************
	// Registers
	// ****************************************
	// Latch and protect bits start cleared at power-up
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_reg <= '0;
			s_reg.sclk_m <= 1'b0;
			s_reg.cs_m <= 1'b1;
			s_reg.cs_s <= 1'b1;
			s_reg.cs_d <= 1'b1;
			s_reg.wp_m <= 1'b1;
			s_reg.wp_s <= 1'b1;
			s_reg.hd_m <= 1'b1;
			s_reg.hd_s <= 1'b1;
			s_reg.bp <= `FSPR_RST_BP;
			s_reg.tb <= `FSPR_RST_BIT;
			s_reg.pdis <= `FSPR_RST_BIT;
			s_reg.hrsel <= `FSPR_RST_BIT;
			s_reg.gran4k <= `FSPR_RST_BIT;
			s_reg.st <= ST_IDLE;
			s_reg.op <= OP_PROG;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// Outputs, all straight from flops
	// ****************************************
	assign o_so = s_reg.so;
	assign o_so_oe = s_reg.so_oe;
	assign o_wip = s_reg.write_in_progress;
	assign o_wel = s_reg.write_enable_latch;
	assign o_bp = s_reg.bp;
	assign o_tb = s_reg.tb;
	assign o_ebl = s_reg.boot_lock_enable;
	assign o_gran4k = s_reg.gran4k;
	assign o_otp_mode = s_reg.otp_mode;
	assign o_otp_lock = s_reg.otp_lock;
	assign o_hold = s_reg.hold;
	assign o_pin_reset = s_reg.pin_reset;
	assign o_array_start = s_reg.start;
	assign o_array_op = s_reg.op;
	assign o_array_addr = s_reg.a_addr;
	assign o_array_otp = s_reg.a_otp;

endmodule

/* File: tb/fspr_host.sv */
module fspr_host (
	output logic o_sclk, // Serial clock
	output logic o_cs_n, // Chip select
	output logic o_di, // Serial data to device
	input wire logic i_so // Serial data from device
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle: clock parked low, device deselected
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_di = 1'b1;
	end

	// ********
	// One frame, MSB first, mode 0, 160 ns per bit
	// ********
	// Sampling late in the high phase leaves room for the sync lag
	task automatic xfer(input int n, input logic [39:0] d, output logic [7:0] rd);
		rd = 8'h00;
		o_cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			o_di = d[i];
			#80 o_sclk = 1'b1;
			#70 rd = {rd[6:0], i_so};
			#10 o_sclk = 1'b0;
		end
		#80 o_cs_n = 1'b1;
		o_di = ~o_di; // No pull on the line: show the inverse
		#240;
	endtask
endmodule

/* File: tb/fspr_top_sva.sv */
module fspr_top_sva (
	input wire logic i_sys_clk, // Clock
	input wire logic i_rst_n, // Reset
	input wire logic i_quad_mode, // Quad in use
	input wire logic i_array_done, // Engine done
	input wire logic o_wip, // Busy
	input wire logic o_wel, // Latch
	input wire logic [3:0] o_bp, // Protect code
	input wire logic o_tb, // Side select
	input wire logic o_ebl, // Boot lock
	input wire logic o_otp_mode, // OTP view
	input wire logic o_otp_lock, // OTP lock
	input wire logic o_hold, // Hold
	input wire logic o_pin_reset, // Pin reset
	input wire logic o_array_start, // Start
	input wire logic [1:0] o_array_op // Operation
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	// ********
	// Status and protection relations
	// ********
	property p_start_busy;
		o_array_start |-> o_wip && o_wel;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start without busy");
	property p_start_pulse;
		o_array_start |=> !o_array_start && $stable(o_array_op);
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
	property p_sw_busy;
		$rose(o_wip) && !o_array_start |-> o_wip [*8];
	endproperty
	a_sw_busy: assert property (p_sw_busy) else $error("status write too short");
	property p_chip_clear;
		o_array_start && o_array_op == 2'h3 |-> o_bp == 4'h0 && !o_ebl && !o_otp_mode;
	endproperty
	a_chip_clear: assert property (p_chip_clear) else $error("chip erase protected");
	property p_done_clear;
		o_wip && i_array_done |=> !o_wip && !o_wel;
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("done left busy");
	property p_wip_fall;
		$fell(o_wip) |-> !o_wel;
	endproperty
	a_wip_fall: assert property (p_wip_fall) else $error("latch kept after write");
	property p_wip_wel;
		$rose(o_wip) |-> o_wel;
	endproperty
	a_wip_wel: assert property (p_wip_wel) else $error("busy without latch");
	property p_lock_keep;
		o_otp_lock |=> o_otp_lock;
	endproperty
	a_lock_keep: assert property (p_lock_keep) else $error("otp lock cleared");
	property p_tb_otp;
		$changed(o_tb) |-> o_otp_mode;
	endproperty
	a_tb_otp: assert property (p_tb_otp) else $error("side changed outside otp");
	property p_hold_excl;
		o_hold |-> !o_pin_reset;
	endproperty
	a_hold_excl: assert property (p_hold_excl) else $error("hold and reset both");
	property p_quad_pins;
		i_quad_mode ##1 i_quad_mode |-> !o_hold && !o_pin_reset;
	endproperty
	a_quad_pins: assert property (p_quad_pins) else $error("pin active in quad");
endmodule

/* File: tb/fspr_top_tb.sv */
module fspr_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst_n = 1'b0, sclk, cs_n, di, so, so_oe, write_in_progress, write_enable_latch, tb, boot_lock_enable, gran;
	logic wp_n = 1'b1, hold_n = 1'b1, quad = 1'b0, done = 1'b0;
	logic otp, lock, hold, prst, start, a_otp;
	logic [3:0] bp;
	logic [1:0] op;
	logic [23:0] addr;
	logic [7:0] rd;
	logic [7:0] opc [5] = '{8'h02, 8'h32, 8'h20, 8'hd8, 8'hc7};
	int len [5] = '{40, 40, 32, 32, 8};
	int failures = 0, checked = 0, starts = 0;

	always #10 clk = ~clk;

	fspr_top fspr_top_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_di(di), .i_wp_n(wp_n), .i_hold_n(hold_n), .i_quad_mode(quad),
		.i_array_done(done), .o_so(so), .o_so_oe(so_oe), .o_wip(write_in_progress), .o_wel(write_enable_latch),
		.o_bp(bp), .o_tb(tb), .o_ebl(boot_lock_enable), .o_gran4k(gran), .o_otp_mode(otp),
		.o_otp_lock(lock), .o_hold(hold), .o_pin_reset(prst), .o_array_start(start),
		.o_array_op(op), .o_array_addr(addr), .o_array_otp(a_otp));
	// Undriven data line reads as the inverse, so a late enable corrupts the byte
	fspr_host fspr_host_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_di(di),
		.i_so(so_oe ? so : ~so));

	// Engine stand-in: finishes one cycle after each start
	always @(posedge clk) begin
		done <= #1 start;
		if (start === 1'b1)
			starts <= starts + 1;
	end

	// ********
	// Access tasks
	// ********
	task automatic check(input string name, input logic [23:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] c);
		fspr_host_inst.xfer(8, {32'h0, c}, rd);
	endtask
	task automatic wr(input logic [7:0] d);
		fspr_host_inst.xfer(16, {24'h0, 8'h01, d}, rd);
	endtask
	task automatic status(input logic [7:0] exp);
		fspr_host_inst.xfer(16, {32'h05, 8'h00}, rd);
		check("status", rd, exp);
	endtask
	// Bounded wait for the busy flag to drop
	task automatic wait_idle();
		int n;
		n = 0;
		while (write_in_progress !== 1'b0 && n < 1000) begin
			@(posedge clk);
			#1 n++;
		end
		if (write_in_progress !== 1'b0) begin
			failures++;
			complete_run();
		end
	endtask
	task automatic swrite(input logic [7:0] d);
		cmd(8'h06);
		wr(d);
		wait_idle();
	endtask
	// Array command with address; go says whether the engine must start
	task automatic arr(input logic [7:0] c, input logic [23:0] a, input logic go);
		int n;
		n = starts;
		cmd(8'h06);
		fspr_host_inst.xfer(32, {8'h00, c, a}, rd);
		check("go", 24'(starts - n), 24'(go));
		wait_idle();
	endtask
	task automatic pins(input logic h, w, q);
		@(posedge clk);
		#1 hold_n = h;
		wp_n = w;
		quad = q;
		repeat (6) @(posedge clk);
		#1;
	endtask

	// ********
	// Main sequence
	// ********
	initial begin
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge clk);
		#1 status(8'h00);
		cmd(8'h06);
		status(8'h02);
		cmd(8'h04);
		status(8'h00);
		wr(8'h3c);
		check("wip", write_in_progress, 1'b0);
		cmd(8'h06);
		wr(8'h3c);
		status(8'h03);
		wait_idle();
		status(8'h3c);
		// Whole array guarded: erase and chip erase go nowhere
		cmd(8'h06);
		fspr_host_inst.xfer(32, 40'h20012000, rd);
		cmd(8'hc7);
		check("starts", 24'(starts), 24'h0);
		swrite(8'h80);
		pins(1'b1, 1'b0, 1'b0);
		swrite(8'h00);
		cmd(8'h04);
		status(8'h80);
		pins(1'b1, 1'b1, 1'b0);
		swrite(8'h00);
		status(8'h00);
		// Every array operation code but chip erase 60, chip erase c7 last
		for (int k = 0; k < 5; k++) begin
			cmd(8'h06);
			fspr_host_inst.xfer(len[k], {opc[k], 32'h0120005a} >> (40 - len[k]), rd);
			check("start", 24'(starts), 24'(k + 1));
			check("op", op, 24'(k < 2 ? 0 : k - 1));
			check("addr", addr, k < 4 ? 24'h012000 : 24'h0);
			check("wel", write_enable_latch, 1'b0);
		end
		cmd(8'h50);
		wr(8'h14);
		check("wip", write_in_progress, 1'b0);
		status(8'h14);
		// Top side: upper 16 blocks guarded
		arr(8'h02, 24'h7f0000, 1'b0);
		arr(8'h02, 24'h012000, 1'b1);
		pins(1'b0, 1'b1, 1'b0);
		check("hold", {hold, prst}, 2'h2);
		pins(1'b1, 1'b1, 1'b0);
		cmd(8'h3a);
		swrite(8'h3c);
		status(8'h38);
		check("view", {otp, tb, gran}, 3'h7);
		// Unlocked OTP sector programs like a normal one
		arr(8'h02, 24'h000000, 1'b1);
		check("a_otp", a_otp, 1'b1);
		pins(1'b0, 1'b1, 1'b0);
		check("reset", {hold, prst}, 2'h1);
		pins(1'b0, 1'b1, 1'b1);
		check("quad", {hold, prst}, 2'h0);
		pins(1'b1, 1'b1, 1'b0);
		swrite(8'hbc);
		swrite(8'h3c);
		status(8'hb8);
		cmd(8'h04);
		check("otp", otp, 1'b0);
		status(8'h14);
		// Bottom side: low blocks guarded, top block free
		arr(8'h02, 24'h012000, 1'b0);
		arr(8'h02, 24'h7f0000, 1'b1);
		check("a_otp", a_otp, 1'b0);
		// Boot lock on one 4KB bottom sector
		cmd(8'h50);
		wr(8'h40);
		status(8'h40);
		arr(8'h02, 24'h000100, 1'b0);
		arr(8'h02, 24'h001000, 1'b1);
		arr(8'hd8, 24'h000000, 1'b0);
		cmd(8'h06);
		cmd(8'hc7);
		check("starts", 24'(starts), 24'h9);
		// Locked OTP sector refuses program
		cmd(8'h3a);
		arr(8'h02, 24'h000000, 1'b0);
		// Pins disabled: no hold or reset, protect pin ignored
		cmd(8'h50);
		wr(8'h40);
		pins(1'b0, 1'b0, 1'b0);
		check("pdis", {hold, prst}, 2'h0);
		cmd(8'h04);
		cmd(8'h50);
		wr(8'hc0);
		cmd(8'h50);
		wr(8'h40);
		status(8'h40);
		// 64KB boot lock on the top block
		arr(8'h02, 24'h7f0000, 1'b0);
		arr(8'h02, 24'h7e0000, 1'b1);
		complete_run();
	end
endmodule

bind fspr_top fspr_top_sva fspr_top_sva_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
	.i_quad_mode(i_quad_mode), .i_array_done(i_array_done), .o_wip(o_wip), .o_wel(o_wel),
	.o_bp(o_bp), .o_tb(o_tb), .o_ebl(o_ebl), .o_otp_mode(o_otp_mode),
	.o_otp_lock(o_otp_lock), .o_hold(o_hold), .o_pin_reset(o_pin_reset),
	.o_array_start(o_array_start), .o_array_op(o_array_op));
